// ---- design/etp_params.svh ----
// Constants for the eight-bit timer PWM block
`ifndef ETP_PARAMS_SVH
`define ETP_PARAMS_SVH
`define ETP_ADDR_W 4
`define ETP_ADDR_COUNTER 4'h0
`define ETP_ADDR_COMPARE 4'h1
`define ETP_ADDR_MODE 4'h2
`define ETP_ADDR_CLKSEL 4'h3
`define ETP_BIT_ENABLE 7
`define ETP_BIT_PWM 6
`define ETP_BIT_LEVEL 1
`define ETP_BIT_OE 0
`define ETP_MODE_MASK 8'hc3
`define ETP_MODE_RST 8'h00
`define ETP_CMP_RST 8'h00
`define ETP_CLKSEL_RST 3'h0
`define ETP_CNT_ZERO 8'h00
`define ETP_CNT_ONE 8'h01
`define ETP_CNT_MAX 8'hff
`define ETP_DIV_RST 7'h00
`define ETP_DIV_ONE 7'h01
`define ETP_RDATA_ZERO 8'h00
`endif

// ---- design/etp_pkg.sv ----
// Types for the eight-bit timer PWM block
package etp_pkg;
  typedef enum logic [1:0] {
    ETP_IDLE = 2'b00,
    ETP_WAIT = 2'b01,
    ETP_RUN = 2'b10
  } etp_phase_type;

  typedef struct packed {
    logic [6:0] div;
    logic tick;
  } etp_pre_state_type;

  typedef struct packed {
    logic [7:0] shadow;
    logic [7:0] active;
    logic pending;
    logic load_ok;
  } etp_cmp_state_type;

  typedef struct packed {
    logic [7:0] cnt;
    logic [7:0] cnt_buf;
    logic [7:0] mode;
    logic [2:0] clksel;
    logic ff;
    etp_phase_type phase;
    logic pin;
    logic [7:0] rdata;
  } etp_top_state_type;
endpackage

// ---- design/etp_prescaler.sv ----
// Free-running count clock divider
`timescale 1ns/10ps
`default_nettype none
`include "etp_params.svh"
module etp_prescaler
  import etp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Divider select and tick
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  etp_pre_state_type cur;
  etp_pre_state_type nxt;

  function automatic logic etp_div_done(input logic [6:0] d, input logic [2:0] s);
    logic [7:0] m;
    m = (8'h01 << s) - 8'h01;
    return (d & m[6:0]) == m[6:0];
  endfunction

  // Never stopped, so start is not aligned to the count clock
  always_comb begin
    nxt = cur;
    nxt.div = cur.div + `ETP_DIV_ONE; // R14
    nxt.tick = etp_div_done(cur.div, sel_in);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur <= '{div: `ETP_DIV_RST, tick: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign tick_out = cur.tick;
endmodule
`default_nettype wire

// ---- design/etp_cmp_load.sv ----
// Compare value shadow and deferred load
`timescale 1ns/10ps
`default_nettype none
`include "etp_params.svh"
module etp_cmp_load
  import etp_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Software write
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  // Counter events
  input wire logic running_in,
  input wire logic to_max_in,
  input wire logic ovf_in,
  // Values
  output logic [7:0] shadow_out,
  output logic [7:0] active_out,
  output logic load_ok_out
);
  etp_cmp_state_type cur;
  etp_cmp_state_type nxt;

  always_comb begin
    nxt = cur;
    if (!running_in) begin
      nxt.pending = 1'b0;
      nxt.load_ok = 1'b0;
    end
    if (to_max_in) begin
      nxt.load_ok = cur.pending; // R11
    end
    if (ovf_in) begin
      nxt.load_ok = 1'b0; // R12
      if (cur.load_ok) begin
        nxt.active = cur.shadow; // R11
        nxt.pending = 1'b0;
      end
    end
    if (wr_in) begin
      nxt.shadow = wdata_in; // R13
      if (running_in) begin
        nxt.pending = 1'b1;
      end else begin
        nxt.active = wdata_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cur <= '{shadow: `ETP_CMP_RST, active: `ETP_CMP_RST, pending: 1'b0, load_ok: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  assign shadow_out = cur.shadow;
  assign active_out = cur.active;
  assign load_ok_out = cur.load_ok;
endmodule
`default_nettype wire

// ---- design/etp_pwm_top.sv ----
// Eight-bit timer in PWM output mode with register port
//
// Notes on behaviour
// R1: Software clears port latch and direction first.
// R2: Program clock, compare, mode while stopped.
// R3: Mode 41h active-high, 43h active-low, output on.
// R4: Writing configuration keeps output flip-flop unchanged.
// R5: Enable bit starts counting, clearing it stops.
// R6: Output inactive from start until first overflow.
// R7: Overflow drives active level until compare match.
// R8: Match drives inactive until next overflow, repeating.
// R9: Stopping forces the output inactive.
// R10: Period 256 counts, active width equals N.
// R11: Compare written before FF loads next overflow.
// R12: Compare written after FF loads second overflow.
// R13: Compare read returns new value while pending.
// R14: Start may vary by one count clock.
// R15: Counter read through buffer updated at count-up.
// R16: Mode bit 6 selects PWM operation.
// R17: Mode bit 0 enables the PWM output.
// R18: Software spaces compare rewrites three counts apart.
// R19: Counter increments per count clock, wraps FF.
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "etp_params.svh"
module etp_pwm_top
  import etp_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic SYS_RST_IN,
  // Register port
  input wire logic [`ETP_ADDR_W-1:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // PWM pin
  output logic TIMER_OUTPUT_PIN_OUT
);
  etp_top_state_type cur;
  etp_top_state_type nxt;
  logic tick;
  logic running;
  logic pwm_mode;
  logic [7:0] cnt_inc;
  logic to_max;
  logic ovf;
  logic cmp_wr;
  logic mode_wr;
  logic [7:0] shadow;
  logic [7:0] active_cmp;
  logic load_ok;

  function automatic logic etp_hit(input logic [`ETP_ADDR_W-1:0] a, input logic [`ETP_ADDR_W-1:0] r);
    return a == r;
  endfunction

  etp_prescaler u_pre (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .sel_in(cur.clksel),
    .tick_out(tick)
  );

  etp_cmp_load u_cmp (
    .clk_in(REF_CLK_IN),
    .rst_in(SYS_RST_IN),
    .wr_in(cmp_wr),
    .wdata_in(REG_WDATA_IN),
    .running_in(running),
    .to_max_in(to_max),
    .ovf_in(ovf),
    .shadow_out(shadow),
    .active_out(active_cmp),
    .load_ok_out(load_ok)
  );

  // Counter events and register write strobes
  assign running = cur.mode[`ETP_BIT_ENABLE];
  assign pwm_mode = cur.mode[`ETP_BIT_PWM]; // R16
  assign cnt_inc = cur.cnt + `ETP_CNT_ONE;
  assign to_max = running && tick && (cnt_inc == `ETP_CNT_MAX);
  assign ovf = running && tick && (cur.cnt == `ETP_CNT_MAX);
  assign cmp_wr = REG_WR_IN && etp_hit(REG_ADDR_IN, `ETP_ADDR_COMPARE);
  assign mode_wr = REG_WR_IN && etp_hit(REG_ADDR_IN, `ETP_ADDR_MODE);

  always_comb begin
    nxt = cur;
    // Counting and output waveform
    if (running) begin
      if (tick) begin
        nxt.cnt = cnt_inc; // R19
        nxt.cnt_buf = cnt_inc; // R15
        if (pwm_mode) begin
          if (cnt_inc == `ETP_CNT_ZERO) begin
            nxt.ff = 1'b1; // R7
          end
          if (cnt_inc == active_cmp) begin
            nxt.ff = 1'b0; // R8
          end
        end
      end
    end else begin
      nxt.cnt = `ETP_CNT_ZERO; // R5
      nxt.cnt_buf = `ETP_CNT_ZERO;
    end
    // Run phase
    unique case (cur.phase)
      ETP_IDLE: begin
        if (running) begin
          nxt.phase = ETP_WAIT; // R6
        end
      end
      ETP_WAIT: begin
        if (!running) begin
          nxt.phase = ETP_IDLE;
        end else if (ovf) begin
          nxt.phase = ETP_RUN;
        end
      end
      ETP_RUN: begin
        if (!running) begin
          nxt.phase = ETP_IDLE;
        end
      end
      default: begin
        nxt.phase = ETP_IDLE;
      end
    endcase
    // Register writes
    if (mode_wr) begin
      nxt.mode = REG_WDATA_IN & `ETP_MODE_MASK; // R3
      if (running && !REG_WDATA_IN[`ETP_BIT_ENABLE]) begin
        nxt.ff = 1'b0; // R9
      end
    end
    if (REG_WR_IN && etp_hit(REG_ADDR_IN, `ETP_ADDR_CLKSEL)) begin
      nxt.clksel = REG_WDATA_IN[2:0];
    end
    // Pin level from flip-flop, polarity and enable
    if (nxt.mode[`ETP_BIT_OE]) begin
      nxt.pin = nxt.ff ^ nxt.mode[`ETP_BIT_LEVEL]; // R17
    end else begin
      nxt.pin = 1'b0;
    end
    // Register reads
    nxt.rdata = `ETP_RDATA_ZERO;
    if (REG_RD_IN) begin
      unique case (REG_ADDR_IN)
        `ETP_ADDR_COUNTER: nxt.rdata = cur.cnt_buf; // R15
        `ETP_ADDR_COMPARE: nxt.rdata = shadow; // R13
        `ETP_ADDR_MODE: nxt.rdata = cur.mode;
        `ETP_ADDR_CLKSEL: nxt.rdata = {5'h00, cur.clksel};
        default: nxt.rdata = `ETP_RDATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      cur <= '{cnt: `ETP_CNT_ZERO, cnt_buf: `ETP_CNT_ZERO, mode: `ETP_MODE_RST,
               clksel: `ETP_CLKSEL_RST, ff: 1'b0, phase: ETP_IDLE, pin: 1'b0,
               rdata: `ETP_RDATA_ZERO};
    end else begin
      cur <= nxt;
    end
  end

  assign REG_RDATA_OUT = cur.rdata;
  assign TIMER_OUTPUT_PIN_OUT = cur.pin;

  // Checks
  sequence s_overflow;
    running && pwm_mode && ovf && !mode_wr;
  endsequence

  sequence s_match;
    running && pwm_mode && tick && (cnt_inc == active_cmp) && !mode_wr;
  endsequence

  property p_ovf_active;
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      s_overflow and (active_cmp != `ETP_CNT_ZERO) |=> cur.ff;
  endproperty

  property p_match_inactive;
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
      s_match |=> !cur.ff;
  endproperty

  a_overflow_active: assert property (p_ovf_active) // R7
    else $error("overflow did not drive active level");

  a_match_inactive: assert property (p_match_inactive) // R8
    else $error("compare match did not drive inactive level");

  a_stop_inactive: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R9
    mode_wr && running && !REG_WDATA_IN[`ETP_BIT_ENABLE] |=> !cur.ff ##1 (!cur.ff && (cur.cnt == `ETP_CNT_ZERO)))
    else $error("stop did not force inactive output");

  a_wait_holds_low: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R6
    (cur.phase == ETP_WAIT) |-> !cur.ff)
    else $error("output active before first overflow");

  a_config_keeps_ff: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R4
    mode_wr && !running |=> cur.ff == $past(cur.ff))
    else $error("configuration write changed output flip-flop");

  a_count_step: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R19
    running && tick && !mode_wr |=> cur.cnt == $past(cnt_inc))
    else $error("counter did not step on count clock");

  a_wrap_zero: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R10
    ovf && !mode_wr |=> (cur.cnt == `ETP_CNT_ZERO) && (cur.phase == ETP_RUN))
    else $error("counter did not wrap to zero at overflow");

  a_pin_level: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R3
    cur.pin == (cur.mode[`ETP_BIT_OE] && (cur.ff ^ cur.mode[`ETP_BIT_LEVEL])))
    else $error("pin level disagrees with polarity and enable");

  a_cmp_readback: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R13
    cmp_wr ##1 (REG_RD_IN && etp_hit(REG_ADDR_IN, `ETP_ADDR_COMPARE) && !REG_WR_IN)
      |=> REG_RDATA_OUT == $past(REG_WDATA_IN, 2))
    else $error("compare read did not return written value");

  a_cnt_buffer: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R15
    REG_RD_IN && etp_hit(REG_ADDR_IN, `ETP_ADDR_COUNTER) |=> REG_RDATA_OUT == $past(cur.cnt_buf))
    else $error("counter read did not come from buffer");

  a_deferred_load: assert property (@(posedge REF_CLK_IN) disable iff (SYS_RST_IN) // R11
    ovf && load_ok |=> active_cmp == $past(shadow))
    else $error("pending compare not loaded at overflow");
endmodule
`default_nettype wire

// ---- dv/etp_pwm_sink.sv ----
// External circuit that receives and measures the PWM pin
`timescale 1ns/10ps
`default_nettype none
module etp_pwm_sink (
  // Clock and control
  input wire logic clk_in,
  input wire logic clr_in,
  // PWM pin from the timer
  input wire logic pin_in,
  // Count of high cycles since clear
  output logic [15:0] high_out
);
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      high_out <= 16'h0000;
    end else if (pin_in) begin
      high_out <= high_out + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the PWM timer
`timescale 1ns/10ps
`default_nettype none
`include "etp_params.svh"
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic pin;
  logic clr = 1'b0;
  logic [15:0] high;
  logic [7:0] got, a, n, m;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;
  int div, lvl;

  etp_pwm_top dut (.REF_CLK_IN(clk), .SYS_RST_IN(rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TIMER_OUTPUT_PIN_OUT(pin));
  etp_pwm_sink sink (.clk_in(clk), .clr_in(clr), .pin_in(pin), .high_out(high));

  always #2.5 clk = ~clk;

  task automatic complete_run;
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      complete_run;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] ad, output logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic measure(input int w);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (w) @(posedge clk);
    #1;
  endtask

  function automatic logic [15:0] exp_high(input logic [7:0] c, input int low, input int dv);
    return 16'((low != 0 ? 256 - int'(c) : int'(c)) * dv);
  endfunction

  initial begin
    void'($urandom(32'h19f38e1f));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd_reg((i == 4) ? 4'h5 : 4'(i), got);
      chk("reset read", 16'h0000, {8'h00, got});
    end
    wr_reg(`ETP_ADDR_MODE, 8'h3c);
    rd_reg(`ETP_ADDR_MODE, got);
    chk("reserved bits", 16'h0000, {8'h00, got});
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      lvl = i % 2;
      div = 1 << (i / 2 % 2);
      wr_reg(`ETP_ADDR_CLKSEL, 8'(i / 2 % 2));
      wr_reg(`ETP_ADDR_COMPARE, n);
      rd_reg(`ETP_ADDR_COMPARE, got);
      chk("compare", {8'h00, n}, {8'h00, got});
      wr_reg(`ETP_ADDR_MODE, 8'h41 | 8'(lvl << 1));
      repeat (2) @(posedge clk);
      #1;
      chk("pin after setup", 16'(lvl), {15'h0000, pin});
      wr_reg(`ETP_ADDR_MODE, 8'hc1 | 8'(lvl << 1));
      measure(200);
      chk("before overflow", 16'(lvl * 200), high);
      repeat (400 * div) @(posedge clk);
      measure(256 * div);
      chk("active width", exp_high(n, lvl, div), high);
      wr_reg(`ETP_ADDR_MODE, 8'h41 | 8'(lvl << 1));
      repeat (2) @(posedge clk);
      #1;
      chk("pin stopped", 16'(lvl), {15'h0000, pin});
    end
    wr_reg(`ETP_ADDR_CLKSEL, 8'h00);
    wr_reg(`ETP_ADDR_COMPARE, 8'h40);
    wr_reg(`ETP_ADDR_MODE, 8'hc1);
    rd_reg(`ETP_ADDR_COUNTER, a);
    rd_reg(`ETP_ADDR_COUNTER, got);
    chk("counter step", 16'h0002, 16'(got - a));
    repeat (10) @(posedge clk);
    m = 8'($urandom) | 8'h01;
    wr_reg(`ETP_ADDR_COMPARE, m);
    rd_reg(`ETP_ADDR_COMPARE, got);
    chk("pending compare", {8'h00, m}, {8'h00, got});
    repeat (600) @(posedge clk);
    measure(256);
    chk("new width", {8'h00, m}, high);
    wr_reg(`ETP_ADDR_MODE, 8'hc0);
    measure(256);
    chk("output disabled", 16'h0000, high);
    wr_reg(`ETP_ADDR_MODE, 8'h41);
    wr_reg(`ETP_ADDR_MODE, 8'h81);
    repeat (300) @(posedge clk);
    measure(256);
    chk("non pwm mode", 16'h0000, high);
    wr_reg(`ETP_ADDR_MODE, 8'h41);
    repeat (3) @(posedge clk);
    rd_reg(`ETP_ADDR_COUNTER, got);
    chk("counter stopped", 16'h0000, {8'h00, got});
    complete_run;
  end
endmodule
`default_nettype wire
